// [rtl/lcis_top.sv]
// Channel alarm status, sticky interrupt flags and masks behind an AXI4-Lite slave.
// Assumes alarm and event inputs come from other logic domains and are resynchronised here.
//
// Notes on behaviour
// - Alarm/code mask: 0 enables, 1 masks; reserved 4..2.
// - Error mask bits 5..2 mask bipolar/excess-zero events.
// - Error mask bit 0 gates counter overflow.
// - Error mask bit 1 gates pattern error.
// - Status registers read-only, reset zero, reserved bits.
// - Status bit 7 shows automatic loopback active.
// - Status bit 4 shows driver over-current.
// - Status bit 3 shows transmit clock missing.
// - Bits 2,1 show transmit and system signal loss.
// - Bit 0 shows line signal loss.
// - Second status bits 7,6 show alarm indication.
// - Second status bit 5 shows pattern sync.
// - Up code status after 40 ms or 5.1 s.
// - Down code after 40/30 ms or 5.1 s.
// - Flags sticky, reset zero, write one clears.
// - Set flag reported on the interrupt output.
// - Over-current flag edge chosen by select bit 4.
// - Clock-missing flag edge chosen by select bit 3.
// - Transmit loss flag edge chosen by select bit 2.
// - Both loss flags share select bit 1.
// - Flags 7..5 latch amplitude and jitter FIFO faults.
// - First mask: one bit per flag, default masked.
// - Pattern-sync flag edge chosen by select bit 5.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module lcis_top
  import lcis_pkg::*;
#(
  parameter int unsigned LOOP_SHORT_CYC_P = lcis_pkg::LOOP_SHORT_CYC,
  parameter int unsigned LOOP_E1_CYC_P = lcis_pkg::LOOP_E1_CYC,
  parameter int unsigned LOOP_LONG_CYC_P = lcis_pkg::LOOP_LONG_CYC
)
(
  // Clock, reset and enable.
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  // AXI4-Lite write channels.
  input wire logic [lcis_pkg::ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read channels.
  input wire logic [lcis_pkg::ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Live alarm levels.
  input wire logic AUTO_LOOPBACK_ACTIVE_I,
  input wire logic DRIVER_OVERCURRENT_I,
  input wire logic TX_CLOCK_MISSING_I,
  input wire logic TX_SIGNAL_LOSS_I,
  input wire logic SYS_SIGNAL_LOSS_I,
  input wire logic LINE_SIGNAL_LOSS_I,
  input wire logic SYS_ALARM_IND_I,
  input wire logic LINE_ALARM_IND_I,
  input wire logic PATTERN_SYNC_I,
  input wire logic LOOP_CODE_UP_I,
  input wire logic LOOP_CODE_DOWN_I,
  // Fault events, counted on their rising edge.
  input wire logic AMPLITUDE_OVERFLOW_I,
  input wire logic TX_JITTER_FIFO_I,
  input wire logic RX_JITTER_FIFO_I,
  input wire logic SYS_BIPOLAR_VIOLATION_I,
  input wire logic LINE_BIPOLAR_VIOLATION_I,
  input wire logic SYS_EXCESS_ZERO_I,
  input wire logic LINE_EXCESS_ZERO_I,
  input wire logic PATTERN_ERROR_I,
  input wire logic ERROR_COUNTER_OVERFLOW_I,
  // Shared interrupt, active high.
  output logic IRQ_O
);
  import lcis_pkg::*;

  logic [19:0] raw_w;
  logic [19:0] sync1_q;
  logic [19:0] sync2_q;
  logic [8:0] evt_prev_q;
  logic [8:0] evt_rise_w;
  logic [1:0] code_w;
  logic [1:0] code_det_w;
  logic [7:0] line_tx_live_status_d;
  logic [7:0] line_tx_live_status_q;
  logic [7:0] alarm_code_live_status_d;
  logic [7:0] alarm_code_live_status_q;
  logic [7:0] esel_q;
  logic [7:0] mask0_q, mask1_q, mask2_q;
  logic [7:0] ctrl_q;
  logic [7:0] flags0_q, flags1_q, flags2_q;
  logic [7:0] set0_w, set1_w, set2_w;
  logic [7:0] clr0_w, clr1_w, clr2_w;
  logic [7:0] esel0_w, esel1_w;
  logic pend_w;
  logic aw_full_q;
  logic w_full_q;
  logic [5:0] awidx_q;
  logic [7:0] wbyte_q;
  logic wstrb0_q;
  logic do_wr_w;
  logic wr_ok_w;
  logic rd_ok_w;
  logic [7:0] rd_byte_w;
  logic [5:0] aridx_w;
  logic aw_hs_w;
  logic w_hs_w;
  logic ar_hs_w;
  logic bvalid_d;
  logic rvalid_d;
  logic aw_full_d;
  logic w_full_d;

  // All alarm and event pins arrive from other domains, so every one goes through two flops first.
  assign raw_w = {ERROR_COUNTER_OVERFLOW_I, PATTERN_ERROR_I, LINE_EXCESS_ZERO_I,
                  SYS_EXCESS_ZERO_I, LINE_BIPOLAR_VIOLATION_I, SYS_BIPOLAR_VIOLATION_I,
                  RX_JITTER_FIFO_I, TX_JITTER_FIFO_I, AMPLITUDE_OVERFLOW_I,
                  LOOP_CODE_UP_I, LOOP_CODE_DOWN_I, PATTERN_SYNC_I, LINE_ALARM_IND_I,
                  SYS_ALARM_IND_I, LINE_SIGNAL_LOSS_I, SYS_SIGNAL_LOSS_I,
                  TX_SIGNAL_LOSS_I, TX_CLOCK_MISSING_I, DRIVER_OVERCURRENT_I,
                  AUTO_LOOPBACK_ACTIVE_I};

  // Synchroniser and event edge history.
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      sync1_q <= 20'h0;
      sync2_q <= 20'h0;
      evt_prev_q <= 9'h0;
    end
    else if (CE_I)
    begin
      sync1_q <= raw_w;
      sync2_q <= sync1_q;
      evt_prev_q <= sync2_q[19:11];
    end
  end

  // An event counts once per rising edge, however long the pin stays high.
  assign evt_rise_w = sync2_q[19:11] & ~evt_prev_q;
  assign code_w = sync2_q[10:9];

  // Loop code persistence timers; index 0 is the down code, index 1 the up code.
  genvar g;
  for (g = 0; g < 2; g++)
  begin : g_code
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] lim_w;
    // The E1 figure only shortens the down code, and only without automatic loopback.
    assign lim_w = ctrl_q[C_AUTO] ? CNT_W'(LOOP_LONG_CYC_P) :
                   ((g == 0) && ctrl_q[C_E1]) ? CNT_W'(LOOP_E1_CYC_P) :
                   CNT_W'(LOOP_SHORT_CYC_P);
    // Counter saturates one past the limit so it cannot wrap back under it.
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
      if (!RESET_N_I)
        cnt_q <= '0;
      else if (CE_I)
      begin
        if (!code_w[g])
          cnt_q <= '0;
        else if (cnt_q <= lim_w)
          cnt_q <= cnt_q + CNT_W'(1);
      end
    end
    assign code_det_w[g] = cnt_q > lim_w;
  end

  // Live status; reserved bits are tied low.
  assign line_tx_live_status_d = {sync2_q[0], 2'h0, sync2_q[1], sync2_q[2], sync2_q[3],
                    sync2_q[4], sync2_q[5]};
  assign alarm_code_live_status_d = {sync2_q[6], sync2_q[7], sync2_q[8], 3'h0,
                    code_det_w[1], code_det_w[0]};

  // Per-bit "either edge" selects; the loss and alarm pairs share one select each.
  assign esel0_w = {3'h0, esel_q[ES_TOC], esel_q[ES_TCKL], esel_q[ES_TLOS],
                    esel_q[ES_LOS], esel_q[ES_LOS]};
  assign esel1_w = {esel_q[ES_AIS], esel_q[ES_AIS], esel_q[ES_PA], 3'h0,
                    esel_q[ES_IB], esel_q[ES_IB]};

  // Rising edge always sets; a falling edge sets only where either-edge is selected.
  assign set0_w = {evt_rise_w[0], evt_rise_w[1], evt_rise_w[2],
                   5'h0} | ((line_tx_live_status_d & ~line_tx_live_status_q) | ((line_tx_live_status_d ^ line_tx_live_status_q) & esel0_w)) &
                  8'h1f;
  assign set1_w = (alarm_code_live_status_d & ~alarm_code_live_status_q) | ((alarm_code_live_status_d ^ alarm_code_live_status_q) & esel1_w);
  assign set2_w = {2'h0, evt_rise_w[3], evt_rise_w[4], evt_rise_w[5], evt_rise_w[6],
                   evt_rise_w[7], evt_rise_w[8]};

  // Write-one-to-clear strobes from the bus.
  assign clr0_w = (do_wr_w && wstrb0_q && awidx_q == IDX_FLAG0) ? wbyte_q : ZERO8;
  assign clr1_w = (do_wr_w && wstrb0_q && awidx_q == IDX_FLAG1) ? wbyte_q : ZERO8;
  assign clr2_w = (do_wr_w && wstrb0_q && awidx_q == IDX_FLAG2) ? wbyte_q : ZERO8;

  // Status and sticky flags; a set in the clearing cycle wins so no event is lost.
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      line_tx_live_status_q <= ZERO8;
      alarm_code_live_status_q <= ZERO8;
      flags0_q <= ZERO8;
      flags1_q <= ZERO8;
      flags2_q <= ZERO8;
    end
    else if (CE_I)
    begin
      line_tx_live_status_q <= line_tx_live_status_d;
      alarm_code_live_status_q <= alarm_code_live_status_d;
      flags0_q <= (flags0_q & ~clr0_w) | set0_w;
      flags1_q <= (flags1_q & ~clr1_w) | set1_w;
      flags2_q <= (flags2_q & ~clr2_w) | set2_w;
    end
  end

  // One shared request from every unmasked flag.
  assign pend_w = |(flags0_q & ~mask0_q) | |(flags1_q & ~mask1_q) |
                  |(flags2_q & ~mask2_q);

  // Bus handshakes; address and data may arrive in either order.
  assign aw_hs_w = AWVALID_I && AWREADY_O;
  assign w_hs_w = WVALID_I && WREADY_O;
  assign ar_hs_w = ARVALID_I && ARREADY_O;
  assign do_wr_w = aw_full_q && w_full_q && !BVALID_O;
  assign aw_full_d = (aw_full_q && !do_wr_w) || aw_hs_w;
  assign w_full_d = (w_full_q && !do_wr_w) || w_hs_w;
  assign bvalid_d = (BVALID_O && !BREADY_I) || do_wr_w;
  assign rvalid_d = (RVALID_O && !RREADY_I) || ar_hs_w;
  assign aridx_w = ARADDR_I[7:2];

  // Address decode; status registers are read-only and refuse writes.
  assign wr_ok_w = awidx_q == IDX_EDGE_SEL || awidx_q == IDX_MASK0 ||
                   awidx_q == IDX_MASK1 || awidx_q == IDX_MASK2 ||
                   awidx_q == IDX_FLAG0 || awidx_q == IDX_FLAG1 ||
                   awidx_q == IDX_FLAG2 || awidx_q == IDX_CTRL;
  assign rd_ok_w = (aridx_w >= IDX_EDGE_SEL) && (aridx_w <= IDX_CTRL);
  assign rd_byte_w = aridx_w == IDX_EDGE_SEL ? esel_q :
                     aridx_w == IDX_MASK0 ? mask0_q :
                     aridx_w == IDX_MASK1 ? mask1_q :
                     aridx_w == IDX_MASK2 ? mask2_q :
                     aridx_w == IDX_LINE_TX_LIVE_STATUS ? line_tx_live_status_q :
                     aridx_w == IDX_ALARM_CODE_LIVE_STATUS ? alarm_code_live_status_q :
                     aridx_w == IDX_FLAG0 ? flags0_q :
                     aridx_w == IDX_FLAG1 ? flags1_q :
                     aridx_w == IDX_FLAG2 ? flags2_q :
                     aridx_w == IDX_CTRL ? ctrl_q : ZERO8;

  // Bus slave state and registered answers.
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      aw_full_q <= 1'h0;
      w_full_q <= 1'h0;
      awidx_q <= 6'h0;
      wbyte_q <= ZERO8;
      wstrb0_q <= 1'h0;
      AWREADY_O <= 1'h0;
      WREADY_O <= 1'h0;
      BVALID_O <= 1'h0;
      BRESP_O <= RESP_OKAY;
      ARREADY_O <= 1'h0;
      RVALID_O <= 1'h0;
      RDATA_O <= 32'h0;
      RRESP_O <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      AWREADY_O <= !aw_full_d && !bvalid_d;
      WREADY_O <= !w_full_d && !bvalid_d;
      BVALID_O <= bvalid_d;
      ARREADY_O <= !rvalid_d;
      RVALID_O <= rvalid_d;
      if (aw_hs_w)
        awidx_q <= AWADDR_I[7:2];
      if (w_hs_w)
      begin
        wbyte_q <= WDATA_I[7:0];
        wstrb0_q <= WSTRB_I[0];
      end
      if (do_wr_w)
        BRESP_O <= wr_ok_w ? RESP_OKAY : RESP_SLVERR;
      if (ar_hs_w)
      begin
        RDATA_O <= {24'h0, rd_byte_w};
        RRESP_O <= rd_ok_w ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Software-written control; reserved mask bits keep their reset pattern.
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      esel_q <= ZERO8;
      mask0_q <= MASK0_RST;
      mask1_q <= MASK1_RST;
      mask2_q <= MASK2_RST;
      ctrl_q <= ZERO8;
    end
    else if (CE_I && do_wr_w && wstrb0_q)
    begin
      if (awidx_q == IDX_EDGE_SEL)
        esel_q <= wbyte_q & EDGE_SEL_RW;
      if (awidx_q == IDX_MASK0)
        mask0_q <= wbyte_q;
      if (awidx_q == IDX_MASK1)
        mask1_q <= (wbyte_q & MASK1_RW) | (MASK1_RST & ~MASK1_RW);
      if (awidx_q == IDX_MASK2)
        mask2_q <= wbyte_q & MASK2_RW;
      if (awidx_q == IDX_CTRL)
        ctrl_q <= wbyte_q & CTRL_RW;
    end
  end

  // Registered interrupt output; it lags the flags by one cycle.
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      IRQ_O <= 1'h0;
    else if (CE_I)
      IRQ_O <= pend_w;
  end

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);

  a_irq_follows_pend: assert property (CE_I |=> IRQ_O == $past(pend_w))
    else $error("Interrupt output does not follow unmasked flags.");
  a_flags_sticky: assert property (CE_I |=> ($past(flags0_q) & ~$past(clr0_w) & ~flags0_q) == 8'h00)
    else $error("First flag register lost a bit without a clear.");
  a_toc_fall_sel: assert property ($fell(line_tx_live_status_q[4]) && $past(esel_q[4]) |-> flags0_q[4])
    else $error("Over-current fall did not set its flag.");
  a_toc_rise: assert property ($rose(line_tx_live_status_q[4]) |-> flags0_q[4])
    else $error("Over-current rise did not set its flag.");
  a_clock_fall_sel: assert property ($fell(line_tx_live_status_q[3]) && $past(esel_q[3]) |-> flags0_q[3])
    else $error("Clock-missing fall did not set its flag.");
  a_tlos_fall_quiet: assert property ($fell(line_tx_live_status_q[2]) && !$past(esel_q[2]) &&
      !$past(flags0_q[2]) |-> !flags0_q[2])
    else $error("Transmit loss fall set its flag on rising-only select.");
  a_los_pair_rise: assert property ($rose(line_tx_live_status_q[0]) || $rose(line_tx_live_status_q[1]) |->
      (~flags0_q[1:0] & {$rose(line_tx_live_status_q[1]), $rose(line_tx_live_status_q[0])}) == 2'h0)
    else $error("Line or system loss rise did not set its flag.");
  a_pattern_rise: assert property ($rose(alarm_code_live_status_q[5]) |-> flags1_q[5])
    else $error("Pattern sync rise did not set its flag.");
  a_mask_reserved: assert property (mask1_q[4:2] == 3'h3 && mask2_q[7:6] == 2'h0)
    else $error("Reserved mask bits changed.");
  a_stat_reserved: assert property (line_tx_live_status_q[6:5] == 2'h0 && alarm_code_live_status_q[4:2] == 3'h0)
    else $error("Reserved status bits are not zero.");
endmodule : lcis_top
`default_nettype wire

// [shared/lcis_pkg.sv]
// Register map, field positions, reset values and timing for the channel alarm interrupt block.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
package lcis_pkg;
  // Register indices; the byte address is four times the index.
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_EDGE_SEL = 6'h1a;
  localparam logic [5:0] IDX_MASK0 = 6'h1b;
  localparam logic [5:0] IDX_MASK1 = 6'h1c;
  localparam logic [5:0] IDX_MASK2 = 6'h1d;
  localparam logic [5:0] IDX_LINE_TX_LIVE_STATUS = 6'h1e;
  localparam logic [5:0] IDX_ALARM_CODE_LIVE_STATUS = 6'h1f;
  localparam logic [5:0] IDX_FLAG0 = 6'h20;
  localparam logic [5:0] IDX_FLAG1 = 6'h21;
  localparam logic [5:0] IDX_FLAG2 = 6'h22;
  localparam logic [5:0] IDX_CTRL = 6'h23;
  // Reset values and writable-bit masks.
  localparam logic [7:0] EDGE_SEL_RW = 8'h7f;
  localparam logic [7:0] MASK0_RST = 8'hff;
  localparam logic [7:0] MASK1_RST = 8'hef;
  localparam logic [7:0] MASK1_RW = 8'he3;
  localparam logic [7:0] MASK2_RST = 8'h3f;
  localparam logic [7:0] MASK2_RW = 8'h3f;
  localparam logic [7:0] CTRL_RW = 8'h03;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Edge-select bit positions.
  localparam int ES_IB = 0;
  localparam int ES_LOS = 1;
  localparam int ES_TLOS = 2;
  localparam int ES_TCKL = 3;
  localparam int ES_TOC = 4;
  localparam int ES_PA = 5;
  localparam int ES_AIS = 6;
  // Status bit positions.
  localparam int B_LLOS = 0;
  localparam int B_SLOS = 1;
  localparam int B_TLOS = 2;
  localparam int B_TCKL = 3;
  localparam int B_TOC = 4;
  localparam int B_AUTO_LP = 7;
  localparam int B_IBD = 0;
  localparam int B_IBA = 1;
  localparam int B_PA = 5;
  // Control bit positions.
  localparam int C_AUTO = 0;
  localparam int C_E1 = 1;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Loop code persistence times and their cycle counts.
  localparam longint unsigned CLK_PERIOD_NS = 100;
  localparam longint unsigned LOOP_SHORT_MS = 40;
  localparam longint unsigned LOOP_E1_MS = 30;
  localparam longint unsigned LOOP_LONG_MS = 5100;
  localparam longint unsigned NS_PER_MS = 1000000;
  localparam int unsigned LOOP_SHORT_CYC = 32'(LOOP_SHORT_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned LOOP_E1_CYC = 32'(LOOP_E1_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned LOOP_LONG_CYC = 32'(LOOP_LONG_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam int CNT_W = 26;
endpackage : lcis_pkg

// [tb/tb.sv]
// Self-checking bench for the channel alarm interrupt block: bus, status, flags, masks, irq.
// Assumes the AXI4-Lite slave timing and the short loop-code counts given with the design.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lcis_pkg::*;
  logic clk, rst_n, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr, fb;
  logic [5:0] fr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [10:0] lvl;
  logic [8:0] ev;
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  int error_cnt, tests_run, seed, i;
  // Edge cases: level input, flag bit, edge-select bit; the last two live in the second flag reg.
  int t_in[7] = '{0, 1, 2, 3, 4, 7, 5};
  int t_fb[7] = '{0, 1, 2, 3, 4, 5, 7};
  int t_es[7] = '{1, 1, 2, 3, 4, 5, 6};
  // Loop-code cases: control value, pin, status bit value, persistence limit in cycles.
  logic [7:0] l_ctl[6] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h01, 8'h03};
  int l_pin[6] = '{9, 10, 10, 9, 9, 10};
  logic [7:0] l_bit[6] = '{8'h02, 8'h01, 8'h01, 8'h02, 8'h02, 8'h01};
  int l_lim[6] = '{40, 40, 30, 40, 510, 510};

  // Short counts keep the persistence timers within a quick run.
  lcis_top #(.LOOP_SHORT_CYC_P(40), .LOOP_E1_CYC_P(30), .LOOP_LONG_CYC_P(510)) dut_u (
    .CLK_SYS_I(clk), .RESET_N_I(rst_n), .CE_I(ce),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(4'h1), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .AUTO_LOOPBACK_ACTIVE_I(lvl[8]), .DRIVER_OVERCURRENT_I(lvl[4]),
    .TX_CLOCK_MISSING_I(lvl[3]), .TX_SIGNAL_LOSS_I(lvl[2]), .SYS_SIGNAL_LOSS_I(lvl[1]),
    .LINE_SIGNAL_LOSS_I(lvl[0]), .SYS_ALARM_IND_I(lvl[5]), .LINE_ALARM_IND_I(lvl[6]),
    .PATTERN_SYNC_I(lvl[7]), .LOOP_CODE_UP_I(lvl[9]), .LOOP_CODE_DOWN_I(lvl[10]),
    .AMPLITUDE_OVERFLOW_I(ev[0]), .TX_JITTER_FIFO_I(ev[1]), .RX_JITTER_FIFO_I(ev[2]),
    .SYS_BIPOLAR_VIOLATION_I(ev[3]), .LINE_BIPOLAR_VIOLATION_I(ev[4]),
    .SYS_EXCESS_ZERO_I(ev[5]), .LINE_EXCESS_ZERO_I(ev[6]), .PATTERN_ERROR_I(ev[7]),
    .ERROR_COUNTER_OVERFLOW_I(ev[8]), .IRQ_O(irq)
  );

  // Free-running 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // One comparison of a result against its expectation.
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // A wait that ran out counts as a mismatch and closes the run.
  task automatic hang;
    error_cnt++;
    $display("wrong value at %0t: got %h expected %h (no answer)", $time, 1'b0, 1'b1);
    end_sim();
  endtask : hang

  // Bus write; each channel is held until its own ready is sampled high.
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] r);
    int n;
    wr_q.push_back(r);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
    if (n == 100) hang();
  endtask : wr

  // Bus read; the expected word and response are noted for the monitor.
  task automatic rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] r);
    int n;
    rd_q.push_back({r, 24'h0, d});
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    rready <= 1'b0;
    if (n == 100) hang();
  endtask : rd

  // Drives one alarm level and lets it pass the synchronisers and the status flop.
  task automatic set_lvl(input int k, input logic val);
    @(posedge clk);
    lvl <= (lvl & ~(11'h1 << k)) | (11'(val) << k);
    repeat (6) @(posedge clk);
  endtask : set_lvl

  // Interrupt level two edges after a completed write.
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    chk({33'h0, irq}, {33'h0, e});
  endtask : irq_is

  // Takes the oldest note off the queue whenever the slave answers.
  always @(posedge clk)
  begin
    if (bvalid && bready && wr_q.size() > 0) chk({32'h0, bresp}, {32'h0, wr_q.pop_front()});
    if (rvalid && rready && rd_q.size() > 0) chk({rresp, rdata}, rd_q.pop_front());
  end

  // Main sequence.
  initial
  begin
    seed = 1467;
    error_cnt = 0;
    tests_run = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    lvl = 11'h000;
    ev = 9'h000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, reserved mask bits, read-only status and unmapped places.
    rd(IDX_MASK0, MASK0_RST, RESP_OKAY);
    rd(IDX_MASK1, 8'hef, RESP_OKAY);
    rd(IDX_MASK2, 8'h3f, RESP_OKAY);
    rd(IDX_LINE_TX_LIVE_STATUS, 8'h00, RESP_OKAY);
    rd(IDX_ALARM_CODE_LIVE_STATUS, 8'h00, RESP_OKAY);
    rd(IDX_FLAG0, 8'h00, RESP_OKAY);
    wr(IDX_MASK1, 8'h00, RESP_OKAY);
    rd(IDX_MASK1, 8'h0c, RESP_OKAY);
    wr(IDX_MASK1, 8'hff, RESP_OKAY);
    wr(IDX_MASK2, 8'hff, RESP_OKAY);
    rd(IDX_MASK2, 8'h3f, RESP_OKAY);
    wr(IDX_LINE_TX_LIVE_STATUS, 8'hff, RESP_SLVERR);
    rd(IDX_LINE_TX_LIVE_STATUS, 8'h00, RESP_OKAY);
    wr(6'h3f, 8'hff, RESP_SLVERR);
    rd(6'h3f, 8'h00, RESP_SLVERR);
    // Random alarm levels show in the live status registers.
    repeat (4)
    begin
      @(posedge clk);
      lvl <= {2'b00, 9'($random(seed))};
      repeat (6) @(posedge clk);
      rd(IDX_LINE_TX_LIVE_STATUS, {lvl[8], 2'b00, lvl[4:0]}, RESP_OKAY);
      rd(IDX_ALARM_CODE_LIVE_STATUS, {lvl[5], lvl[6], lvl[7], 5'h00}, RESP_OKAY);
    end
    @(posedge clk);
    lvl <= 11'h000;
    repeat (6) @(posedge clk);
    wr(IDX_FLAG0, 8'hff, RESP_OKAY);
    wr(IDX_FLAG1, 8'hff, RESP_OKAY);
    rd(IDX_FLAG0, 8'h00, RESP_OKAY);
    // Rising edge only with select low, both edges with select high.
    for (i = 0; i < 7; i++)
    begin
      fr = (i < 5) ? IDX_FLAG0 : IDX_FLAG1;
      fb = 8'(1 << t_fb[i]);
      wr(IDX_EDGE_SEL, 8'h00, RESP_OKAY);
      set_lvl(t_in[i], 1'b1);
      rd(fr, fb, RESP_OKAY);
      wr(fr, fb, RESP_OKAY);
      set_lvl(t_in[i], 1'b0);
      rd(fr, 8'h00, RESP_OKAY);
      wr(IDX_EDGE_SEL, 8'(1 << t_es[i]), RESP_OKAY);
      set_lvl(t_in[i], 1'b1);
      wr(fr, fb, RESP_OKAY);
      set_lvl(t_in[i], 1'b0);
      rd(fr, fb, RESP_OKAY);
      wr(fr, fb, RESP_OKAY);
    end
    // A pulse that comes and goes while the clock enable is low must leave no trace.
    @(posedge clk);
    ce <= 1'b0;
    ev <= 9'h001;
    repeat (3) @(posedge clk);
    ev <= 9'h000;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    rd(IDX_FLAG0, 8'h00, RESP_OKAY);
    // Fault events latch flags; each third-mask bit, and first-mask bit 7, alone lets its flag reach the interrupt.
    for (i = 0; i < 9; i++)
    begin
      @(posedge clk);
      ev <= 9'h1 << i;
      @(posedge clk);
      ev <= 9'h000;
      repeat (4) @(posedge clk);
      // Events 0..2 land on first-register bits 7..5, events 3..8 on third-register bits 5..0.
      fr = (i < 3) ? IDX_FLAG0 : IDX_FLAG2;
      fb = (i < 3) ? 8'(8'hff << (7 - i)) : 8'(8'h3f << (8 - i)) & 8'h3f;
      rd(fr, fb, RESP_OKAY);
    end
    repeat (6) @(posedge clk);
    rd(IDX_FLAG0, 8'he0, RESP_OKAY);
    rd(IDX_FLAG2, 8'h3f, RESP_OKAY);
    irq_is(1'b0);
    for (i = 0; i < 6; i++)
    begin
      wr(IDX_MASK2, 8'h3f & ~(8'h1 << i), RESP_OKAY);
      irq_is(1'b1);
      wr(IDX_MASK2, 8'h3f, RESP_OKAY);
      irq_is(1'b0);
    end
    wr(IDX_MASK0, 8'h7f, RESP_OKAY);
    irq_is(1'b1);
    wr(IDX_FLAG0, 8'h80, RESP_OKAY);
    irq_is(1'b0);
    rd(IDX_FLAG0, 8'h60, RESP_OKAY);
    wr(IDX_MASK0, 8'hff, RESP_OKAY);
    // Loop-code persistence: short, E1 and automatic-loopback limits.
    for (i = 0; i < 6; i++)
    begin
      wr(IDX_CTRL, l_ctl[i], RESP_OKAY);
      set_lvl(l_pin[i], 1'b1);
      repeat (l_lim[i] - 16) @(posedge clk);
      rd(IDX_ALARM_CODE_LIVE_STATUS, 8'h00, RESP_OKAY);
      repeat (16) @(posedge clk);
      rd(IDX_ALARM_CODE_LIVE_STATUS, l_bit[i], RESP_OKAY);
      set_lvl(l_pin[i], 1'b0);
    end
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule : tb
`default_nettype wire
